// ---- rtl/iec_regs.vh ----
// Register map, field positions and reset values of the interrupt entry control block.
// Included by the top-level design file of the block; definitions only.
`ifndef IEC_REGS_VH
`define IEC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets on the Avalon-MM slave (one 32-bit word each)
`define IEC_OFS_ENABLE     4'h0
`define IEC_OFS_REQUEST    4'h4
`define IEC_OFS_EDGE       4'h8
`define IEC_OFS_STATE      4'hc

////////////////////////////////////////////////////////////////////////////////
// Source bit positions in the enable and request registers
`define IEC_SRC_EXT_ZERO   0
`define IEC_SRC_EXT_ONE    1
`define IEC_SRC_PERIPH_LO  2

// Edge select fields, two bits per external source
`define IEC_EDGE_ZERO_LSB  0
`define IEC_EDGE_ONE_LSB   2
`define IEC_EDGE_BOTH      2'h0
`define IEC_EDGE_RISE      2'h1
`define IEC_EDGE_FALL      2'h2

// State register bits
`define IEC_ST_GIE         0
`define IEC_ST_IN_SERVICE  1
`define IEC_ST_OVERFLOW    2
`define IEC_ST_UNDERFLOW   3

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define IEC_RST_EDGE       4'h0
`define IEC_RST_GIE        1'b0
`define IEC_RST_RDATA      32'h0000_0000

`endif

// ---- rtl/iec_save_mem.v ----
// Small save stack memory for accumulator and flags pairs.
// Assumes one clock; read data comes out of a register one cycle after rd_en_in.
`timescale 1ns/1ps

module iec_save_mem #(
	parameter WIDTH = 12,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             sys_clk_in,
	input  wire             rst_b_in,
	input  wire             wr_en_in,
	input  wire [AW-1:0]    wr_addr_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             rd_en_in,
	input  wire [AW-1:0]    rd_addr_in,
	output reg  [WIDTH-1:0] rd_data_out
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

	////////////////////////////////////////////////////////////////////////////////
	// Storage array, no reset: contents only matter after a push
	always @(posedge sys_clk_in) begin
		if (wr_en_in)
			mem_reg[wr_addr_in] <= wr_data_in;
	end

	// Registered read port
	always @(posedge sys_clk_in) begin
		if (!rst_b_in)
			rd_data_out <= {WIDTH{1'b0}};
		else if (rd_en_in)
			rd_data_out <= mem_reg[rd_addr_in];
	end

endmodule

// ---- rtl/iec_top.v ----
// Interrupt entry control: source flags, enable mask, global enable, entry/return
// sequencing and accumulator/flags save stack for a small 8-bit core.
// Assumes the core drives its instruction strobes as one-cycle pulses on sys_clk_in,
// and software reaches the registers over an Avalon-MM master.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "iec_regs.vh"

module iec_top #(
	parameter NUM_PERIPH = 6,
	parameter SRC0_ALT   = 0,
	parameter SRC1_ALT   = 0,
	parameter SAVE_DEPTH = 4,
	parameter SAVE_AW    = 2
) (
	input  wire                  sys_clk_in,
	input  wire                  rst_b_in,
	// Avalon-MM slave
	input  wire [3:0]            avs_address_in,
	input  wire                  avs_read_in,
	input  wire                  avs_write_in,
	input  wire [31:0]           avs_writedata_in,
	output reg  [31:0]           avs_readdata_out,
	output reg                   avs_waitrequest_out,
	// Pins and peripheral events
	input  wire                  port_a_bit_zero_in,
	input  wire                  port_b_bit_five_in,
	input  wire                  port_b_bit_zero_in,
	input  wire                  port_a_bit_four_in,
	input  wire [NUM_PERIPH-1:0] periph_evt_in,
	// Core side
	input  wire                  int_take_in,
	input  wire                  reti_in,
	input  wire                  engint_in,
	input  wire                  disgint_in,
	input  wire                  pushaf_in,
	input  wire                  popaf_in,
	input  wire [7:0]            acc_in,
	input  wire [3:0]            flags_in,
	output reg                   irq_req_out,
	output wire [7:0]            acc_out,
	output wire [3:0]            flags_out,
	output reg                   pop_valid_out
);

	localparam NSRC = NUM_PERIPH + 2;

	// Stack pointer bounds at the pointer's own width
	localparam [SAVE_AW:0] SP_FULL  = SAVE_DEPTH[SAVE_AW:0];
	localparam [SAVE_AW:0] SP_EMPTY = {(SAVE_AW+1){1'b0}};

	////////////////////////////////////////////////////////////////////////////////
	// Register map, one 32-bit word each, unused bits read zero
	//   0x0 enable mask, one bit per source, no reset
	//   0x4 request flags, same layout, write one to clear, no reset
	//   0x8 edge select, bits 1:0 source zero, bits 3:2 source one
	//   0xc state: global enable, in service, stack overflow, stack underflow
	// Source bits: 0 external zero, 1 external one, peripherals from 2 up
	// Edge codes: 1 rising only, 2 falling only, 0 and 3 both edges
	// Global enable and in service are read-only; only the core moves them
	// Stack errors are sticky, write one to clear
	//
	// Core strobes are one-cycle pulses. Within one cycle a take beats
	// disable, and disable beats enable or return.
	// Return leaves the flags alone: software clears the served flag
	// first, or the request comes straight back after return.
	// Save stack is last in first out, SAVE_DEPTH words of accumulator
	// and flags; a push when full or a pop when empty is dropped.

	reg  [NSRC-1:0]    enable_reg;
	reg  [NSRC-1:0]    request_reg;
	reg  [NSRC-1:0]    request_next;
	reg  [3:0]         edge_reg;
	reg                gie_reg;
	reg                gie_next;
	reg                in_service_reg;
	reg                overflow_reg;
	reg                underflow_reg;
	reg  [1:0]         ext_sync1_reg;
	reg  [1:0]         ext_sync2_reg;
	reg  [1:0]         ext_prev_reg;
	reg  [1:0]         ext_evt;
	reg  [1:0]         edge_code;
	reg  [SAVE_AW:0]   sp_reg;
	reg  [31:0]        rdata_next;
	wire [1:0]         ext_raw;
	wire               bus_req;
	wire               bus_do;
	wire               wr_enable;
	wire               wr_request;
	wire               wr_edge;
	wire               wr_state;
	wire               push_ok;
	wire               pop_ok;
	wire [SAVE_AW-1:0] push_addr;
	wire [SAVE_AW-1:0] pop_addr;
	wire [11:0]        save_rd;
	wire [NSRC-1:0]    src_evt;
	wire [NSRC-1:0]    pending;
	wire               push_drop;
	wire               pop_drop;
	wire               clr_overflow;
	wire               clr_underflow;
	integer            i;

	////////////////////////////////////////////////////////////////////////////////
	// External pin choice, fixed at build time
	assign ext_raw[0] = (SRC0_ALT != 0) ? port_b_bit_five_in : port_a_bit_zero_in;
	assign ext_raw[1] = (SRC1_ALT != 0) ? port_a_bit_four_in : port_b_bit_zero_in;

	// Two-stage synchroniser, then a history stage for edge detection.
	// No reset: the chain keeps following the pins, so the history matches
	// the pin level at release and no false edge follows reset.
	always @(posedge sys_clk_in) begin
		ext_sync1_reg <= ext_raw;
		ext_sync2_reg <= ext_sync1_reg;
		ext_prev_reg  <= ext_sync2_reg;
	end

	// Edge qualification, identical for either pin choice
	// Codes 0 and 3 both take either edge
	always @* begin
		ext_evt = 2'h0;
		for (i = 0; i < 2; i = i + 1) begin
			edge_code = edge_reg[2*i +: 2];
			case (edge_code)
				`IEC_EDGE_RISE: ext_evt[i] = ext_sync2_reg[i] & ~ext_prev_reg[i];
				`IEC_EDGE_FALL: ext_evt[i] = ~ext_sync2_reg[i] & ext_prev_reg[i];
				default:        ext_evt[i] = ext_sync2_reg[i] ^ ext_prev_reg[i];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave handshake: one wait cycle, then the completing cycle.
	// A held request sees waitrequest high again, so back-to-back transfers
	// take two edges each; no pipelining, traded for a simple decode.
	// Write strobes below are true only in the completing cycle
	assign bus_req    = avs_read_in | avs_write_in;
	assign bus_do     = bus_req & ~avs_waitrequest_out;
	assign wr_enable  = bus_do & avs_write_in & (avs_address_in == `IEC_OFS_ENABLE);
	assign wr_request = bus_do & avs_write_in & (avs_address_in == `IEC_OFS_REQUEST);
	assign wr_edge    = bus_do & avs_write_in & (avs_address_in == `IEC_OFS_EDGE);
	assign wr_state   = bus_do & avs_write_in & (avs_address_in == `IEC_OFS_STATE);

	// Read mux; unmapped addresses read zero
	always @* begin
		rdata_next = 32'h0000_0000;
		case (avs_address_in)
			`IEC_OFS_ENABLE:  rdata_next[NSRC-1:0] = enable_reg;
			`IEC_OFS_REQUEST: rdata_next[NSRC-1:0] = request_reg;
			`IEC_OFS_EDGE:    rdata_next[3:0] = edge_reg;
			`IEC_OFS_STATE:   rdata_next[3:0] = {underflow_reg, overflow_reg, in_service_reg, gie_reg};
			default:          rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data loads as waitrequest drops, so it stands at the completing edge
	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= `IEC_RST_RDATA;
		end else begin
			if (bus_req & avs_waitrequest_out) begin
				avs_waitrequest_out <= 1'b0;
				avs_readdata_out    <= rdata_next;
			end else begin
				avs_waitrequest_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mask has no reset; software loads it before enabling
	always @(posedge sys_clk_in) begin
		if (wr_enable)
			enable_reg <= avs_writedata_in[NSRC-1:0];
	end

	// Peripheral events above the two external sources
	assign src_evt = {periph_evt_in, ext_evt};

	// Flags: write one clears, a new event in the same cycle wins
	always @* begin
		request_next = request_reg;
		if (wr_request)
			request_next = request_next & ~avs_writedata_in[NSRC-1:0];
		request_next = request_next | src_evt;
	end

	// No reset on the flags either; the entry path is guarded by the global enable
	always @(posedge sys_clk_in) begin
		request_reg <= request_next;
	end

	always @(posedge sys_clk_in) begin
		if (!rst_b_in)
			edge_reg <= `IEC_RST_EDGE;
		else if (wr_edge)
			edge_reg <= avs_writedata_in[3:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Global enable; entry and disable take priority over enable in one cycle
	// A return in the same cycle as a take loses, so the new entry holds
	always @* begin
		gie_next = gie_reg;
		if (reti_in)
			gie_next = 1'b1;
		if (engint_in)
			gie_next = 1'b1;
		if (disgint_in)
			gie_next = 1'b0;
		if (int_take_in)
			gie_next = 1'b0;
	end

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			gie_reg        <= `IEC_RST_GIE;
			in_service_reg <= 1'b0;
		end else begin
			gie_reg <= gie_next;
			if (int_take_in)
				in_service_reg <= 1'b1;
			else if (reti_in)
				in_service_reg <= 1'b0;
		end
	end

	// Sources that would interrupt if the global enable allowed it
	assign pending = enable_reg & request_next;

	// Request to the core; global enable low forces it off even with unknown mask
	always @(posedge sys_clk_in) begin
		if (!rst_b_in)
			irq_req_out <= 1'b0;
		else
			irq_req_out <= gie_next & (|pending);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Save stack; a push beyond depth or a pop from empty is dropped and flagged
	assign push_ok   = pushaf_in & (sp_reg != SP_FULL);
	assign pop_ok    = popaf_in & ~pushaf_in & (sp_reg != SP_EMPTY);
	assign push_addr = sp_reg[SAVE_AW-1:0];
	assign pop_addr  = sp_reg[SAVE_AW-1:0] - {{(SAVE_AW-1){1'b0}}, 1'b1};

	// Dropped stack requests and software clears of the sticky errors
	assign push_drop     = pushaf_in & ~push_ok;
	assign pop_drop      = popaf_in & ~pushaf_in & ~pop_ok;
	assign clr_overflow  = wr_state & avs_writedata_in[`IEC_ST_OVERFLOW];
	assign clr_underflow = wr_state & avs_writedata_in[`IEC_ST_UNDERFLOW];

	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			sp_reg        <= SP_EMPTY;
			overflow_reg  <= 1'b0;
			underflow_reg <= 1'b0;
			pop_valid_out <= 1'b0;
		end else begin
			pop_valid_out <= pop_ok;
			if (push_ok)
				sp_reg <= sp_reg + {{SAVE_AW{1'b0}}, 1'b1};
			else if (pop_ok)
				sp_reg <= sp_reg - {{SAVE_AW{1'b0}}, 1'b1};
			// Sticky errors: set wins over the write-one clear
			overflow_reg  <= (overflow_reg & ~clr_overflow) | push_drop;
			underflow_reg <= (underflow_reg & ~clr_underflow) | pop_drop;
		end
	end

	// Accumulator in the upper byte, flags in the low nibble
	// Read data is registered in the memory, so the restored pair
	// shows the cycle after the pop, together with pop_valid_out
	iec_save_mem #(
		.WIDTH (12),
		.DEPTH (SAVE_DEPTH),
		.AW    (SAVE_AW)
	) u_save (
		.sys_clk_in  (sys_clk_in),
		.rst_b_in    (rst_b_in),
		.wr_en_in    (push_ok),
		.wr_addr_in  (push_addr),
		.wr_data_in  ({acc_in, flags_in}),
		.rd_en_in    (pop_ok),
		.rd_addr_in  (pop_addr),
		.rd_data_out (save_rd)
	);

	assign acc_out   = save_rd[11:4];
	assign flags_out = save_rd[3:0];

endmodule

// ---- verification/iec_checker.sv ----
// Concurrent checks on the interrupt entry control top-level ports.
// Assumes one clock and a synchronous active-low reset held two edges or more.
`timescale 1ns/1ps
module iec_checker (
	input wire logic       sys_clk_in,
	input wire logic       rst_b_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic       avs_waitrequest_out,
	input wire logic       int_take_in,
	input wire logic       disgint_in,
	input wire logic       pushaf_in,
	input wire logic       popaf_in,
	input wire logic       irq_req_out,
	input wire logic       pop_valid_out,
	input wire logic [7:0] acc_out,
	input wire logic [3:0] flags_out
);
	////////////////////////////////////////////////////////////////////////////////
	// One domain, so clock and disable are given once
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	take_clears_a: assert property (int_take_in |=> !irq_req_out)
		else $error("irq still up after take");
	block_all_a: assert property (disgint_in |=> !irq_req_out)
		else $error("irq up after global disable");
	rise_cause_a: assert property ($rose(irq_req_out) |-> !$past(int_take_in) && !$past(disgint_in))
		else $error("irq rose right after take or disable");
	req_holds_a: assert property (irq_req_out && !int_take_in && !disgint_in && !avs_write_in |=> irq_req_out)
		else $error("irq dropped without cause");
	pop_cause_a: assert property (pop_valid_out |-> $past(popaf_in) && !$past(pushaf_in))
		else $error("pop valid without lone pop");
	pop_hold_a: assert property (!pop_valid_out |-> $stable(acc_out) && $stable(flags_out))
		else $error("restored values moved without pop");
	bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer late");
	bus_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
endmodule

bind iec_top iec_checker iec_checker_inst (.sys_clk_in, .rst_b_in, .avs_read_in, .avs_write_in,
	.avs_waitrequest_out, .int_take_in, .disgint_in, .pushaf_in, .popaf_in, .irq_req_out,
	.pop_valid_out, .acc_out, .flags_out);

// ---- verification/iec_core_model.sv ----
// Core-side partner: vectors into the service routine when a request is seen.
// Assumes the bench drives the other instruction strobes itself.
`timescale 1ns/1ps
module iec_core_model (
	input  wire logic sys_clk_in,
	input  wire logic rst_b_in,
	input  wire logic irq_req_in,
	input  wire logic slow_in,
	output logic      int_take_out
);
	logic [1:0] wait_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Slow mode models an instruction still finishing before vectoring
	always @(posedge sys_clk_in) begin
		int_take_out <= 1'b0;
		if (!rst_b_in || !irq_req_in || int_take_out) begin
			wait_reg <= slow_in ? 2'h3 : 2'h0;
		end else if (wait_reg != 2'h0) begin
			wait_reg <= wait_reg - 2'h1;
		end else begin
			int_take_out <= 1'b1;
		end
	end
endmodule

// ---- verification/iec_top_bench.sv ----
// Self-checking bench for the interrupt entry control block.
// Assumes default build options: source zero on port A bit zero, source one on port B bit zero.
`timescale 1ns/1ps
module iec_top_bench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  pins = 4'h0;
	logic [5:0]  evt = 6'h0;
	logic [4:0]  strb = 5'h0;
	logic [7:0]  acc = 8'h0;
	logic [3:0]  flg = 4'h0;
	logic        slow = 1'b0;
	logic [31:0] q;
	wire  [31:0] rdata;
	wire  [7:0]  acc_o;
	wire  [3:0]  flg_o;
	wire         wreq, irq, take, popv;
	integer      failures = 0;
	integer      cmp_count = 0;
	integer      cycles = 0;

	always #5 clk = ~clk;

	// Pins: [0] a0, [1] b5, [2] b0, [3] a4; strobes: reti, engint, disgint, push, pop
	iec_top iec_top_inst (.sys_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.port_a_bit_zero_in(pins[0]), .port_b_bit_five_in(pins[1]), .port_b_bit_zero_in(pins[2]),
		.port_a_bit_four_in(pins[3]), .periph_evt_in(evt), .int_take_in(take), .reti_in(strb[4]),
		.engint_in(strb[3]), .disgint_in(strb[2]), .pushaf_in(strb[1]), .popaf_in(strb[0]), .acc_in(acc),
		.flags_in(flg), .irq_req_out(irq), .acc_out(acc_o), .flags_out(flg_o), .pop_valid_out(popv));
	iec_core_model iec_core_model_inst (.sys_clk_in(clk), .rst_b_in(rst_b), .irq_req_in(irq),
		.slow_in(slow), .int_take_out(take));

	////////////////////////////////////////////////////////////////////////////////
	// Closing report and hang guard
	task stop_test;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			stop_test;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access tasks; the master waits on waitrequest, never on a fixed count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		@(posedge clk);
		while (wreq !== 1'b0)
			@(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register", e, q);
	endtask

	task pulse(input logic [4:0] s, input logic [5:0] e);
		@(posedge clk);
		strb <= s;
		evt <= e;
		@(posedge clk);
		strb <= 5'h00;
		evt <= 6'h00;
	endtask

	task pin(input logic [3:0] p);
		@(posedge clk);
		pins <= p;
		repeat (5) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rchk(4'hc, 32'h0);
		bus(1'b1, 4'h8, 32'h0);
		bus(1'b1, 4'h0, 32'h4);
		bus(1'b1, 4'h4, 32'hff);
		pulse(5'h08, 6'h00);
		rchk(4'hc, 32'h1);
		rchk(4'h2, 32'h0);
		pulse(5'h00, 6'h02);
		rchk(4'h4, 32'h8);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, 4'h4, 32'h8);
		$display("setup test done");
		pulse(5'h00, 6'h01);
		repeat (3) @(posedge clk);
		rchk(4'hc, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		rchk(4'h4, 32'h4);
		acc <= 8'ha5;
		flg <= 4'h9;
		pulse(5'h02, 6'h00);
		acc <= 8'h3c;
		flg <= 4'h6;
		pulse(5'h02, 6'h00);
		pulse(5'h01, 6'h00);
		@(posedge clk);
		chk("pop", 32'h13c6, {19'h0, popv, acc_o, flg_o});
		pulse(5'h01, 6'h00);
		@(posedge clk);
		chk("pop", 32'h1a59, {19'h0, popv, acc_o, flg_o});
		pulse(5'h01, 6'h00);
		@(posedge clk);
		chk("pop", 32'h0a59, {19'h0, popv, acc_o, flg_o});
		repeat (5) pulse(5'h02, 6'h00);
		rchk(4'hc, 32'he);
		bus(1'b1, 4'hc, 32'hc);
		rchk(4'hc, 32'h2);
		bus(1'b1, 4'h4, 32'h4);
		pulse(5'h10, 6'h00);
		rchk(4'hc, 32'h1);
		$display("entry test done");
		slow <= 1'b1;
		pulse(5'h04, 6'h00);
		pulse(5'h00, 6'h01);
		repeat (6) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		pulse(5'h08, 6'h00);
		repeat (8) @(posedge clk);
		rchk(4'hc, 32'h2);
		bus(1'b1, 4'h4, 32'h4);
		pulse(5'h10, 6'h00);
		$display("block test done");
		pin(4'b0010);
		rchk(4'h4, 32'h0);
		pin(4'b0011);
		rchk(4'h4, 32'h1);
		bus(1'b1, 4'h4, 32'h1);
		pin(4'b1011);
		rchk(4'h4, 32'h0);
		pin(4'b1111);
		rchk(4'h4, 32'h2);
		bus(1'b1, 4'h8, 32'h9);
		bus(1'b1, 4'h4, 32'h3);
		pin(4'b1010);
		rchk(4'h4, 32'h2);
		bus(1'b1, 4'h4, 32'h2);
		pin(4'b1111);
		rchk(4'h4, 32'h1);
		$display("pin test done");
		stop_test;
	end
endmodule
